// ### verilog/rcp_pkg.sv
// Package for the reset-cause and power-mode sequencer: addresses, fields, reset values, counts, states
package rcp_pkg;

  // ********************************
  // Register addresses
  // ********************************
  localparam logic [7:0] RCP_ADDR_PMC = 8'h87;
  localparam logic [7:0] RCP_ADDR_RCV = 8'hB1;
  localparam logic [7:0] RCP_ADDR_CKC = 8'hB6;
  localparam logic [7:0] RCP_ADDR_WRC = 8'hAD;

  // ********************************
  // Field positions
  // ********************************
  localparam int RCP_PMC_IDLE = 0;
  localparam int RCP_PMC_STOP = 1;
  localparam int RCP_PMC_UF0 = 2;
  localparam int RCP_PMC_UF1 = 3;
  localparam int RCP_PMC_BAUD = 7;
  localparam int RCP_RCV_CAUSE = 0;
  localparam int RCP_RCV_ROM = 1;
  localparam int RCP_CKC_HALT = 1;
  localparam int RCP_WRC_BUSY = 4;

  // Reserved bits 6..4 never stored
  localparam logic [7:0] RCP_PMC_MASK = 8'h8F;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] RCP_PMC_INIT = 8'h00;
  localparam logic [1:0] RCP_RCV_INIT = 2'h2;
  localparam logic [1:0] RCP_RCV_WDT = 2'h1;
  localparam logic [7:0] RCP_CKC_INIT = 8'h00;

  // ********************************
  // Reset vectors
  // ********************************
  localparam logic [15:0] RCP_VEC_RAM = 16'h0000;
  localparam logic [15:0] RCP_VEC_ROM = 16'h8000;

  // ********************************
  // Startup counts
  // ********************************
  localparam logic [7:0] RCP_SLOW_POR = 8'h0E;
  localparam logic [7:0] RCP_SLOW_WDT = 8'h0C;
  localparam logic [7:0] RCP_SLOW_EXT = 8'h03;
  localparam logic [7:0] RCP_SLOW_RTC = 8'h03;
  localparam logic [7:0] RCP_XTAL_RST = 8'h18;
  localparam logic [7:0] RCP_XTAL_WAKE = 8'h34;

  typedef enum logic [3:0] {
    RCP_ST_RST_LOAD = 4'b0000,
    RCP_ST_RST_SLOW = 4'b0001,
    RCP_ST_RST_XTAL = 4'b0010,
    RCP_ST_RUN = 4'b0011,
    RCP_ST_IDLE = 4'b0100,
    RCP_ST_STOP = 4'b0101,
    RCP_ST_PD_CLK = 4'b0110,
    RCP_ST_PD_REG = 4'b0111,
    RCP_ST_PD_SLEEP = 4'b1000,
    RCP_ST_WAKE_SLOW = 4'b1001,
    RCP_ST_WAKE_XTAL = 4'b1010
  } rcp_state_e;

endpackage : rcp_pkg

// ### verilog/rcp_cnt_if.sv
// Interface between the sequencer and one of its down counters
`timescale 1ns/100ps
interface rcp_cnt_if;
  logic load;
  logic [7:0] load_val;
  logic step;
  logic zero;

  modport ctl (output load, output load_val, output step, input zero);
  modport cnt (input load, input load_val, input step, output zero);
endinterface : rcp_cnt_if

// ### verilog/rcp_cnt.sv
// Loadable down counter used for slow-oscillator and crystal startup counts
`timescale 1ns/100ps
module rcp_cnt (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  rcp_cnt_if.cnt cif
);

  logic [7:0] count_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_r <= 8'h00;
    end else if (cif.load) begin
      count_r <= cif.load_val;
    end else if (cif.step && (count_r != 8'h00)) begin
      count_r <= count_r - 8'h01;
    end
  end

  // Zero only when not being reloaded, so a load never looks done
  assign cif.zero = (count_r == 8'h00) && !cif.load;

endmodule : rcp_cnt

// ### verilog/rcp_sync.sv
// Three-stage synchroniser with rising-edge pulse for the slow oscillator pin
`timescale 1ns/100ps
module rcp_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Pin side
  input wire logic pin_in,
  // Synchronised side
  output logic rise
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts only when the two later stages agree
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
      rise <= (s2_r == s3_r) && s3_r && !level_r;
    end
  end

endmodule : rcp_sync

// ### verilog/rcp_seq.sv
// Reset-cause, reset-vector and power-mode sequencer with its special function registers
// Functional notes
// - Cause bit 0: 0 power-on, 1 other
// - Cleared cause bit requests code reload
// - Bit 1 picks vector 0x0000 or 0x8000
// - Cause register two bits, reset value 02
// - Watchdog reset resumes loaded program at zero
// - Idle bit suspends CPU after instruction completes
// - Enabled interrupt clears idle, CPU resumes
// - Watchdog reset ends idle, full reset
// - Stop bit suspends; only watchdog ends it
// - Clock-halt bit: controlled clock/regulator shutdown
// - Power-down ends on external, RTC, watchdog
// - Watchdog in power-down runs full reset
// - Reset startup: 14/12 slow plus 24 crystal
// - Wake: 3 slow plus 52 crystal cycles
// - Power bit 7 doubles baud; 6-4 reserved
// - Power bits 3,2 are plain user flags
// - Interface control bit 4 reads busy
`timescale 1ns/100ps
module rcp_seq
  import rcp_pkg::*;
(
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // CPU core
  input wire logic instr_done,
  input wire logic irq_wake,
  output logic cpu_hold,
  output logic cpu_reset,
  output logic [15:0] reset_vector,
  output logic boot_reload,
  output logic baud_doubler,
  // Wake and reset sources
  input wire logic wdt_reset,
  input wire logic ext_irq_wake,
  input wire logic rtc_wake,
  input wire logic wrc_busy,
  // Slow oscillator pin
  input wire logic slow_oscillator,
  // Power control
  output logic clk_stop,
  output logic regulator_off,
  output logic idle_active,
  output logic stop_active,
  output logic power_down
);

  // ********************************
  // Declarations
  // ********************************
  rcp_state_e state_r;
  rcp_state_e state_nxt;
  logic [7:0] pmc_r;
  logic [7:0] pmc_nxt;
  logic [1:0] rcv_r;
  logic [1:0] rcv_nxt;
  logic [7:0] ckc_r;
  logic [7:0] ckc_nxt;
  logic slow_rise;
  logic idle_clr;
  logic halt_clr;
  logic in_reset;
  logic [7:0] read_mux;

  rcp_cnt_if slow_if ();
  rcp_cnt_if xtal_if ();

  // ********************************
  // Submodules
  // ********************************
  rcp_sync u_slow_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in(slow_oscillator),
    .rise(slow_rise)
  );

  rcp_cnt u_slow_cnt (
    .sys_clk(sys_clk),
    .reset(reset),
    .cif(slow_if.cnt)
  );

  rcp_cnt u_xtal_cnt (
    .sys_clk(sys_clk),
    .reset(reset),
    .cif(xtal_if.cnt)
  );

  // ********************************
  // Register access decode
  // ********************************
  wire wr_pmc = sfr_wr && !in_reset && (sfr_addr == RCP_ADDR_PMC);
  wire wr_rcv = sfr_wr && !in_reset && (sfr_addr == RCP_ADDR_RCV);
  wire wr_ckc = sfr_wr && !in_reset && (sfr_addr == RCP_ADDR_CKC);

  assign in_reset = (state_r == RCP_ST_RST_LOAD) || (state_r == RCP_ST_RST_SLOW) ||
                    (state_r == RCP_ST_RST_XTAL);

  always_comb begin
    if (sfr_addr == RCP_ADDR_PMC) begin
      read_mux = pmc_r & RCP_PMC_MASK;
    end else if (sfr_addr == RCP_ADDR_RCV) begin
      read_mux = {6'h00, rcv_r};
    end else if (sfr_addr == RCP_ADDR_CKC) begin
      read_mux = ckc_r;
    end else if (sfr_addr == RCP_ADDR_WRC) begin
      read_mux = 8'h00;
      read_mux[RCP_WRC_BUSY] = wrc_busy;
    end else begin
      read_mux = 8'h00;
    end
  end

  // ********************************
  // Register next values
  // ********************************
  always_comb begin
    pmc_nxt = pmc_r;
    rcv_nxt = rcv_r;
    ckc_nxt = ckc_r;
    if (idle_clr) begin
      pmc_nxt[RCP_PMC_IDLE] = 1'b0;
    end
    if (halt_clr) begin
      ckc_nxt[RCP_CKC_HALT] = 1'b0;
    end
    // A software write in the same cycle wins over a hardware clear
    if (wr_pmc) begin
      pmc_nxt = sfr_wdata & RCP_PMC_MASK;
    end
    if (wr_rcv) begin
      rcv_nxt = sfr_wdata[1:0];
    end
    if (wr_ckc) begin
      ckc_nxt = sfr_wdata;
    end
    // Watchdog reset restores power and clock-control registers, cause register loads 01
    if (wdt_reset) begin
      pmc_nxt = RCP_PMC_INIT;
      ckc_nxt = RCP_CKC_INIT;
      rcv_nxt = RCP_RCV_WDT;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pmc_r <= RCP_PMC_INIT;
      rcv_r <= RCP_RCV_INIT;
      ckc_r <= RCP_CKC_INIT;
    end else begin
      pmc_r <= pmc_nxt;
      rcv_r <= rcv_nxt;
      ckc_r <= ckc_nxt;
    end
  end

  // ********************************
  // Sequencer
  // ********************************
  always_comb begin
    state_nxt = state_r;
    slow_if.load = 1'b0;
    slow_if.load_val = 8'h00;
    slow_if.step = slow_rise;
    xtal_if.load = 1'b0;
    xtal_if.load_val = 8'h00;
    xtal_if.step = 1'b1;
    idle_clr = 1'b0;
    halt_clr = 1'b0;
    if (wdt_reset) begin
      state_nxt = RCP_ST_RST_LOAD;
    end else begin
      case (state_r)
        RCP_ST_RST_LOAD: begin
          slow_if.load = 1'b1;
          // Cause bit tells power-on from watchdog start
          slow_if.load_val = rcv_r[RCP_RCV_CAUSE] ? RCP_SLOW_WDT : RCP_SLOW_POR;
          state_nxt = RCP_ST_RST_SLOW;
        end
        RCP_ST_RST_SLOW: begin
          if (slow_if.zero) begin
            xtal_if.load = 1'b1;
            xtal_if.load_val = RCP_XTAL_RST;
            state_nxt = RCP_ST_RST_XTAL;
          end
        end
        RCP_ST_RST_XTAL: begin
          if (xtal_if.zero) begin
            state_nxt = RCP_ST_RUN;
          end
        end
        RCP_ST_RUN: begin
          // Entry only once the setting instruction has completed
          if (instr_done && ckc_r[RCP_CKC_HALT]) begin
            state_nxt = RCP_ST_PD_CLK;
          end else if (instr_done && pmc_r[RCP_PMC_STOP]) begin
            state_nxt = RCP_ST_STOP;
          end else if (instr_done && pmc_r[RCP_PMC_IDLE]) begin
            state_nxt = RCP_ST_IDLE;
          end
        end
        RCP_ST_IDLE: begin
          if (irq_wake) begin
            idle_clr = 1'b1;
            state_nxt = RCP_ST_RUN;
          end
        end
        RCP_ST_STOP: begin
          state_nxt = RCP_ST_STOP;
        end
        RCP_ST_PD_CLK: begin
          // Clock stops one cycle before the regulators drop
          state_nxt = RCP_ST_PD_REG;
        end
        RCP_ST_PD_REG: begin
          state_nxt = RCP_ST_PD_SLEEP;
        end
        RCP_ST_PD_SLEEP: begin
          if (ext_irq_wake) begin
            slow_if.load = 1'b1;
            slow_if.load_val = RCP_SLOW_EXT;
            state_nxt = RCP_ST_WAKE_SLOW;
          end else if (rtc_wake) begin
            slow_if.load = 1'b1;
            slow_if.load_val = RCP_SLOW_RTC;
            state_nxt = RCP_ST_WAKE_SLOW;
          end
        end
        RCP_ST_WAKE_SLOW: begin
          if (slow_if.zero) begin
            xtal_if.load = 1'b1;
            xtal_if.load_val = RCP_XTAL_WAKE;
            state_nxt = RCP_ST_WAKE_XTAL;
          end
        end
        RCP_ST_WAKE_XTAL: begin
          if (xtal_if.zero) begin
            halt_clr = 1'b1;
            state_nxt = RCP_ST_RUN;
          end
        end
        default: begin
          state_nxt = RCP_ST_RST_LOAD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= RCP_ST_RST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ********************************
  // Output decode
  // ********************************
  wire nxt_reset = (state_nxt == RCP_ST_RST_LOAD) || (state_nxt == RCP_ST_RST_SLOW) ||
                   (state_nxt == RCP_ST_RST_XTAL);
  wire nxt_pd = (state_nxt == RCP_ST_PD_CLK) || (state_nxt == RCP_ST_PD_REG) ||
                (state_nxt == RCP_ST_PD_SLEEP) || (state_nxt == RCP_ST_WAKE_SLOW) ||
                (state_nxt == RCP_ST_WAKE_XTAL);
  wire nxt_clk_stop = (state_nxt == RCP_ST_PD_CLK) || (state_nxt == RCP_ST_PD_REG) ||
                      (state_nxt == RCP_ST_PD_SLEEP) || (state_nxt == RCP_ST_WAKE_SLOW);
  wire nxt_reg_off = (state_nxt == RCP_ST_PD_REG) || (state_nxt == RCP_ST_PD_SLEEP);
  wire [15:0] nxt_vector = rcv_nxt[RCP_RCV_ROM] ? RCP_VEC_ROM : RCP_VEC_RAM;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
      cpu_hold <= 1'b1;
      cpu_reset <= 1'b1;
      reset_vector <= RCP_VEC_ROM;
      boot_reload <= 1'b1;
      baud_doubler <= 1'b0;
      clk_stop <= 1'b0;
      regulator_off <= 1'b0;
      idle_active <= 1'b0;
      stop_active <= 1'b0;
      power_down <= 1'b0;
    end else begin
      if (sfr_rd) begin
        sfr_rdata <= read_mux;
      end
      cpu_hold <= (state_nxt != RCP_ST_RUN);
      cpu_reset <= nxt_reset;
      reset_vector <= nxt_vector;
      // Boot loader reloads code RAM while the cause bit reads zero
      boot_reload <= !rcv_nxt[RCP_RCV_CAUSE];
      baud_doubler <= pmc_nxt[RCP_PMC_BAUD];
      clk_stop <= nxt_clk_stop;
      regulator_off <= nxt_reg_off;
      idle_active <= (state_nxt == RCP_ST_IDLE);
      stop_active <= (state_nxt == RCP_ST_STOP);
      power_down <= nxt_pd;
    end
  end

endmodule : rcp_seq

// ### dv/rcp_seq_sva.sv
// Port assertions for the reset-cause and power-mode sequencer
`timescale 1ns/100ps
module rcp_seq_sva
  import rcp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Core side
  input wire logic irq_wake,
  input wire logic cpu_hold,
  input wire logic cpu_reset,
  input wire logic [15:0] reset_vector,
  input wire logic boot_reload,
  // Wake sources
  input wire logic wdt_reset,
  input wire logic ext_irq_wake,
  input wire logic rtc_wake,
  input wire logic wrc_busy,
  // Modes
  input wire logic clk_stop,
  input wire logic regulator_off,
  input wire logic idle_active,
  input wire logic stop_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic [7:0] rst_len_r;

  // Cycles of the current startup, saturating
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_len_r <= 8'h00;
    end else if (!cpu_reset) begin
      rst_len_r <= 8'h00;
    end else if (rst_len_r != 8'hFF) begin
      rst_len_r <= rst_len_r + 8'h01;
    end
  end

  // At least 36 cycles of cpu_reset, 12 plus 24, before release
  start_len_a: assert property ($fell(cpu_reset) |-> rst_len_r >= 8'h24)
    else $error("startup released too early");

  wdt_full_a: assert property (wdt_reset |-> ##[1:2] cpu_reset && cpu_hold)
    else $error("watchdog reset did not restart the core");
  wdt_vector_a: assert property (wdt_reset |-> ##[1:3] reset_vector == RCP_VEC_RAM && !boot_reload)
    else $error("watchdog reset kept the boot vector");
  hold_reset_a: assert property (cpu_reset |-> cpu_hold)
    else $error("core released during startup");
  idle_hold_a: assert property (idle_active |-> cpu_hold)
    else $error("core running in idle");
  idle_exit_a: assert property (idle_active && irq_wake && !wdt_reset |-> ##[1:2] !idle_active && !cpu_hold)
    else $error("interrupt did not end idle");
  stop_keep_a: assert property (stop_active && !wdt_reset && !$past(wdt_reset) |=> stop_active)
    else $error("stop left without watchdog reset");
  pd_order_a: assert property ($rose(clk_stop) && !wdt_reset |=> regulator_off && clk_stop)
    else $error("regulators not shut after clock");
  pd_keep_a: assert property (regulator_off && !(ext_irq_wake || rtc_wake || wdt_reset)
      && !$past(ext_irq_wake || rtc_wake || wdt_reset) |=> regulator_off)
    else $error("power-down left without wake source");
  busy_read_a: assert property (sfr_rd && sfr_addr == RCP_ADDR_WRC |=> sfr_rdata == {3'h0, $past(wrc_busy), 4'h0})
    else $error("busy flag misread");
endmodule : rcp_seq_sva

bind rcp_seq rcp_seq_sva i_rcp_seq_sva (
  .sys_clk(sys_clk),
  .reset(reset),
  .sfr_addr(sfr_addr),
  .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata),
  .irq_wake(irq_wake),
  .cpu_hold(cpu_hold),
  .cpu_reset(cpu_reset),
  .reset_vector(reset_vector),
  .boot_reload(boot_reload),
  .wdt_reset(wdt_reset),
  .ext_irq_wake(ext_irq_wake),
  .rtc_wake(rtc_wake),
  .wrc_busy(wrc_busy),
  .clk_stop(clk_stop),
  .regulator_off(regulator_off),
  .idle_active(idle_active),
  .stop_active(stop_active)
);

// ### dv/rcp_cpu_model.sv
// Far-side model: free-running slow oscillator and watchdog interface busy flag
`timescale 1ns/100ps
module rcp_cpu_model
  import rcp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port seen by the watchdog interface
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  // Towards the sequencer
  output logic slow_oscillator,
  output logic wrc_busy
);
  logic [2:0] div_r;
  logic [3:0] busy_r;

  // Ten sys_clk per slow period keeps startup counts short
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_r <= 3'h0;
      slow_oscillator <= 1'b0;
    end else if (div_r == 3'h4) begin
      div_r <= 3'h0;
      slow_oscillator <= !slow_oscillator;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // Control write keeps the slow interface busy a while
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy_r <= 4'h0;
    end else if (sfr_wr && sfr_addr == RCP_ADDR_WRC) begin
      busy_r <= 4'h8;
    end else if (busy_r != 4'h0) begin
      busy_r <= busy_r - 4'h1;
    end
  end
  assign wrc_busy = busy_r != 4'h0;
endmodule : rcp_cpu_model

// ### dv/rcp_seq_tb.sv
// Self-checking testbench for the reset-cause and power-mode sequencer
`timescale 1ns/100ps
module rcp_seq_tb
  import rcp_pkg::*;
;
  logic sys_clk, reset, sfr_wr, sfr_rd, slow_oscillator, wrc_busy;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
  logic [4:0] ev;
  logic cpu_hold, cpu_reset, boot_reload, baud_doubler, clk_stop, regulator_off;
  logic idle_active, stop_active, power_down;
  logic [15:0] reset_vector;
  int failures = 0;
  int checks_done = 0;
  int n;

  rcp_seq i_rcp_seq (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .instr_done(ev[0]),
    .irq_wake(ev[1]), .cpu_hold(cpu_hold), .cpu_reset(cpu_reset), .reset_vector(reset_vector),
    .boot_reload(boot_reload), .baud_doubler(baud_doubler), .wdt_reset(ev[4]),
    .ext_irq_wake(ev[3]), .rtc_wake(ev[2]), .wrc_busy(wrc_busy), .slow_oscillator(slow_oscillator),
    .clk_stop(clk_stop), .regulator_off(regulator_off), .idle_active(idle_active),
    .stop_active(stop_active), .power_down(power_down));
  rcp_cpu_model i_rcp_cpu_model (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .slow_oscillator(slow_oscillator), .wrc_busy(wrc_busy));

  // ********************************
  // Tasks
  // ********************************
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task rdb(input logic [7:0] a);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 rd = sfr_rdata;
  endtask : rdb

  // Bits: wdt, external, rtc, interrupt, instruction done
  task pulse(input logic [4:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 5'h00;
    @(posedge sys_clk);
    #1;
  endtask : pulse

  task wait_run;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 1000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    // A hang ends the run as a failure
    if (n >= 1000) begin
      failures++;
      stop_test;
    end
  endtask : wait_run

  task stop_test;
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Whole run is about a thousand cycles, a tenth of this 10000-cycle limit
  initial begin
    #200000;
    failures++;
    stop_test;
  end

  initial begin
    reset = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    ev = 5'h00;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1 chk("vector_por", reset_vector, RCP_VEC_ROM);
    chk("reload_por", boot_reload, 16'h1);
    wait_run;
    chk("por_time", n inside {[157:173]}, 16'h1);
    rdb(RCP_ADDR_RCV);
    chk("cause_init", rd, 16'h02);
    rdb(RCP_ADDR_PMC);
    chk("pmc_init", rd, 16'h00);
    wr(RCP_ADDR_PMC, 8'hFC);
    rdb(RCP_ADDR_PMC);
    chk("pmc_flags", rd, 16'h8C);
    chk("baud", baud_doubler, 16'h1);
    wr(8'h90, 8'h55);
    rdb(8'h90);
    chk("unmapped", rd, 16'h00);
    for (int v = 0; v < 4; v++) begin
      wr(RCP_ADDR_RCV, v[7:0]);
      rdb(RCP_ADDR_RCV);
      chk("cause_rw", rd, v[15:0]);
      chk("vector", reset_vector, v[1] ? RCP_VEC_ROM : RCP_VEC_RAM);
      chk("reload", boot_reload, {15'h0, !v[0]});
    end
    wr(RCP_ADDR_WRC, 8'h08);
    rdb(RCP_ADDR_WRC);
    chk("busy_set", rd, 16'h10);
    // Idle entry and interrupt exit
    wr(RCP_ADDR_PMC, 8'h81);
    pulse(5'h01);
    chk("idle", {cpu_hold, idle_active}, 16'h3);
    pulse(5'h02);
    chk("idle_end", {cpu_hold, idle_active}, 16'h0);
    rdb(RCP_ADDR_PMC);
    chk("idle_bit", rd, 16'h80);
    // Stop ignores interrupts and wake sources
    wr(RCP_ADDR_PMC, 8'h02);
    pulse(5'h01);
    pulse(5'h0E);
    chk("stop", {cpu_hold, stop_active}, 16'h3);
    pulse(5'h10);
    chk("wdt_rst", cpu_reset, 16'h1);
    wait_run;
    chk("wdt_time", n inside {[134:152]}, 16'h1);
    rdb(RCP_ADDR_RCV);
    chk("cause_wdt", rd, 16'h01);
    chk("vector_wdt", reset_vector, RCP_VEC_RAM);
    rdb(RCP_ADDR_PMC);
    chk("pmc_wdt", rd, 16'h00);
    // Power-down woken by external, rtc, then external with watchdog
    for (int k = 0; k < 3; k++) begin
      wr(RCP_ADDR_RCV, 8'h02);
      wr(RCP_ADDR_WRC, 8'h08);
      while (wrc_busy !== 1'b0) @(posedge sys_clk);
      wr(RCP_ADDR_CKC, 8'h02);
      pulse(5'h01);
      chk("pd", {clk_stop, regulator_off, power_down}, 16'h7);
      pulse(k == 0 ? 5'h08 : k == 1 ? 5'h04 : 5'h18);
      chk("pd_reset", cpu_reset, k == 2);
      wait_run;
      if (k < 2) begin
        chk("wake_time", n inside {[72:96]}, 16'h1);
        rdb(RCP_ADDR_CKC);
        chk("halt_clear", rd, 16'h00);
      end else begin
        rdb(RCP_ADDR_RCV);
        chk("cause_pd", rd, 16'h01);
      end
    end
    // Second power-on reset in mid-run restores the boot defaults
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    wait_run;
    chk("por2_time", n inside {[157:173]}, 16'h1);
    rdb(RCP_ADDR_RCV);
    chk("cause_por2", rd, 16'h02);
    chk("vector_por2", reset_vector, RCP_VEC_ROM);
    chk("reload_por2", boot_reload, 16'h1);
    stop_test;
  end
endmodule : rcp_seq_tb
